// [ddu_pkg.sv]
// Shared constants and types for the DAC data, update and clear block.
// Assumes one 100 MHz clock and a serial register port sampled on it.
package ddu_pkg;

    // -------------------------------------------------------------------
    // Sizes
    // -------------------------------------------------------------------
    localparam int NUM_CH = 16;
    localparam int CODE_W = 12;
    localparam int NUM_ALARM = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CNT_W = 5;

    // -------------------------------------------------------------------
    // Serial frame: read flag, 7 pad bits, address, data
    // -------------------------------------------------------------------
    localparam logic [CNT_W-1:0] HDR_BITS = 5'h10;
    localparam logic [CNT_W-1:0] FRAME_BITS = 5'h18;

    // -------------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_IF_CFG_ONE = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_UPDATE_CMD = 8'h0F;
    localparam logic [ADDR_W-1:0] ADDR_CLR_EN_0 = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_CLR_EN_1 = 8'h19;
    localparam logic [ADDR_W-1:0] ADDR_CLR_SRC_0 = 8'h1A;
    localparam logic [ADDR_W-1:0] ADDR_CLR_SRC_1 = 8'h1B;
    localparam logic [ADDR_W-1:0] ADDR_DATA_FIRST = 8'h50;
    localparam logic [ADDR_W-1:0] ADDR_DATA_LAST = 8'h6F;
    localparam logic [ADDR_W-1:0] ADDR_ALARM_ST_0 = 8'h70;
    localparam logic [ADDR_W-1:0] ADDR_ALARM_ST_1 = 8'h71;
    localparam logic [ADDR_W-1:0] ADDR_SOFT_CLR_0 = 8'hB0;
    localparam logic [ADDR_W-1:0] ADDR_SOFT_CLR_1 = 8'hB1;

    // -------------------------------------------------------------------
    // Field positions and reset values
    // -------------------------------------------------------------------
    localparam int BIT_SOURCE_SELECT_A = 4;
    localparam int BIT_DAC_UPDATE = 0;
    localparam int ALARM_PIN_BIT = 0;
    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
    localparam logic [NUM_CH-1:0] RST_MASK = 16'h0000;
    localparam logic [NUM_CH-1:0] RST_CLAMP = 16'hFFFF;
    localparam logic [CODE_W-1:0] RST_CODE = 12'h000;
    localparam logic [CODE_W-1:0] ZERO_CODE = 12'h000;

    // -------------------------------------------------------------------
    // Types
    // -------------------------------------------------------------------
    typedef logic [NUM_CH-1:0][CODE_W-1:0] ddu_codes_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ddu_req_t;

    // -------------------------------------------------------------------
    // Data span decode
    // -------------------------------------------------------------------
    function automatic logic ddu_is_data(input logic [ADDR_W-1:0] a);
        return (a >= ADDR_DATA_FIRST) && (a <= ADDR_DATA_LAST);
    endfunction

    function automatic logic [3:0] ddu_chan(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - ADDR_DATA_FIRST;
        return off[4:1];
    endfunction

endpackage

// [ddu_spi_slave.sv]
// Serial register port: 4-wire, mode 0, 24-bit frames.
// Assumes SCLK at most one eighth of i_clk; pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
module ddu_spi_slave (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_csn,
    input wire logic i_sdi,
    input wire logic [ddu_pkg::DATA_W-1:0] i_rd_data,
    output logic o_rd_req,
    output logic o_wr_req,
    output ddu_pkg::ddu_req_t o_req,
    output logic o_sdo,
    output logic o_sdo_oe
);
    import ddu_pkg::*;

    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    logic sclk_s1, sclk_s2, sclk_d;
    logic csn_n_s1, csn_n_s2;
    logic sdi_s1, sdi_s2;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_d <= 1'b0;
            csn_n_s1 <= 1'b1;
            csn_n_s2 <= 1'b1;
            sdi_s1 <= 1'b0;
            sdi_s2 <= 1'b0;
        end else begin
            sclk_s1 <= i_sclk;
            sclk_s2 <= sclk_s1;
            sclk_d <= sclk_s2;
            csn_n_s1 <= i_csn;
            csn_n_s2 <= csn_n_s1;
            sdi_s1 <= i_sdi;
            sdi_s2 <= sdi_s1;
        end
    end

    // -------------------------------------------------------------------
    // Frame shifter
    // -------------------------------------------------------------------
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [FRAME_BITS-1:0] rx, next_rx;
    logic [DATA_W-1:0] tx, next_tx;
    logic next_sdo, next_oe, next_rd, next_wr;
    ddu_req_t next_req;
    logic sclk_rise, sclk_fall;

    always_comb begin
        sclk_rise = sclk_s2 & ~sclk_d;
        sclk_fall = ~sclk_s2 & sclk_d;
        next_cnt = cnt;
        next_rx = rx;
        next_tx = tx;
        next_sdo = o_sdo;
        next_oe = ~csn_n_s2;
        next_rd = 1'b0;
        next_wr = 1'b0;
        next_req = o_req;
        if (csn_n_s2) begin
            next_cnt = '0;
            next_sdo = 1'b0;
        end else begin
            if (sclk_rise && cnt != FRAME_BITS) begin
                next_rx = {rx[FRAME_BITS-2:0], sdi_s2};
                next_cnt = CNT_W'(cnt + 1'b1);
                // Address known after the header: fetch read data early
                if (cnt == HDR_BITS - 1'b1 && rx[HDR_BITS-2]) begin
                    next_rd = 1'b1;
                    next_req.addr = next_rx[ADDR_W-1:0];
                end
                if (cnt == FRAME_BITS - 1'b1 && !rx[FRAME_BITS-2]) begin
                    next_wr = 1'b1;
                    next_req.addr = next_rx[DATA_W +: ADDR_W];
                    next_req.wdata = next_rx[DATA_W-1:0];
                end
            end
            if (sclk_fall) begin
                if (cnt == HDR_BITS) begin
                    next_sdo = i_rd_data[DATA_W-1];
                    next_tx = {i_rd_data[DATA_W-2:0], 1'b0};
                end else begin
                    next_sdo = tx[DATA_W-1];
                    next_tx = {tx[DATA_W-2:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt <= '0;
            rx <= '0;
            tx <= '0;
            o_sdo <= 1'b0;
            o_sdo_oe <= 1'b0;
            o_rd_req <= 1'b0;
            o_wr_req <= 1'b0;
            o_req <= '0;
        end else begin
            cnt <= next_cnt;
            rx <= next_rx;
            tx <= next_tx;
            o_sdo <= next_sdo;
            o_sdo_oe <= next_oe;
            o_rd_req <= next_rd;
            o_wr_req <= next_wr;
            o_req <= next_req;
        end
    end

endmodule
`default_nettype wire

// [ddu_dac_regs.sv]
// DAC data registers with double buffering, global update and clear.
// Assumes a host on the serial port and alarm events from on-chip logic.
`timescale 1ns/10ps
`default_nettype none
module ddu_dac_regs (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_csn,
    input wire logic i_sdi,
    output logic o_sdo,
    output logic o_sdo_oe,
    input wire logic i_alarm_input_pin,
    input wire logic [ddu_pkg::NUM_ALARM-2:0] i_alarm_event,
    output ddu_pkg::ddu_codes_t o_dac_code,
    output logic [ddu_pkg::NUM_CH-1:0] o_dac_clear,
    output logic [ddu_pkg::NUM_CH-1:0] o_dac_clamp
);
    import ddu_pkg::*;

    // -------------------------------------------------------------------
    // Serial port
    // -------------------------------------------------------------------
    logic rd_req, wr_req;
    ddu_req_t req;
    logic [DATA_W-1:0] rd_data, next_rd_data;

    ddu_spi_slave u_spi (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_sclk(i_sclk),
        .i_csn(i_csn),
        .i_sdi(i_sdi),
        .i_rd_data(rd_data),
        .o_rd_req(rd_req),
        .o_wr_req(wr_req),
        .o_req(req),
        .o_sdo(o_sdo),
        .o_sdo_oe(o_sdo_oe)
    );

    // -------------------------------------------------------------------
    // Alarm pin synchroniser
    // -------------------------------------------------------------------
    logic alarm_pin_s1, alarm_pin_s2;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            alarm_pin_s1 <= 1'b0;
            alarm_pin_s2 <= 1'b0;
        end else begin
            alarm_pin_s1 <= i_alarm_input_pin;
            alarm_pin_s2 <= alarm_pin_s1;
        end
    end

    // -------------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------------
    logic [DATA_W-1:0] if_cfg_one, next_if_cfg_one;
    logic [NUM_CH-1:0] clr_en, next_clr_en;
    logic [NUM_ALARM-1:0] clr_src, next_clr_src;
    logic [NUM_CH-1:0] soft_clr, next_soft_clr;
    logic [NUM_ALARM-1:0] alarm_st, next_alarm_st;
    logic [NUM_ALARM-1:0] alarm_evt, alarm_w1c;
    logic [CODE_W-1:0] buffer_reg [NUM_CH];
    logic [CODE_W-1:0] next_buffer [NUM_CH];
    logic [CODE_W-1:0] active_reg [NUM_CH];
    logic [CODE_W-1:0] next_active [NUM_CH];
    logic [NUM_CH-1:0] chan_clear, next_clamp;
    ddu_codes_t next_code;
    logic wr_data, wr_update, alarm_clears;
    logic [3:0] wr_ch, rd_ch;
    logic [CODE_W-1:0] rd_code;

    always_comb begin
        next_if_cfg_one = if_cfg_one;
        next_clr_en = clr_en;
        next_clr_src = clr_src;
        next_soft_clr = soft_clr;
        next_buffer = buffer_reg;
        next_active = active_reg;
        next_clamp = o_dac_clamp;
        alarm_w1c = '0;
        wr_data = wr_req && ddu_is_data(req.addr);
        wr_ch = ddu_chan(req.addr);
        wr_update = wr_req && req.addr == ADDR_UPDATE_CMD
            && req.wdata[BIT_DAC_UPDATE];
        if (wr_req) begin
            case (req.addr)
                ADDR_IF_CFG_ONE: next_if_cfg_one = req.wdata;
                ADDR_CLR_EN_0: next_clr_en[7:0] = req.wdata;
                ADDR_CLR_EN_1: next_clr_en[15:8] = req.wdata;
                ADDR_CLR_SRC_0: next_clr_src[7:0] = req.wdata;
                ADDR_CLR_SRC_1: next_clr_src[15:8] = req.wdata;
                ADDR_SOFT_CLR_0: next_soft_clr[7:0] = req.wdata;
                ADDR_SOFT_CLR_1: next_soft_clr[15:8] = req.wdata;
                ADDR_ALARM_ST_0: alarm_w1c[7:0] = req.wdata;
                ADDR_ALARM_ST_1: alarm_w1c[15:8] = req.wdata;
                default: ;
            endcase
        end
        // Writes only touch the buffer, even while cleared
        if (wr_data) begin
            if (!req.addr[0]) begin
                next_buffer[wr_ch][DATA_W-1:0] = req.wdata;
            end else begin
                next_buffer[wr_ch][CODE_W-1:DATA_W] =
                    req.wdata[CODE_W-DATA_W-1:0];
            end
        end
        // Global transfer; a clamped channel is released by it
        if (wr_update) begin
            next_active = buffer_reg;
            next_clamp = '0;
        end
    end

    // -------------------------------------------------------------------
    // Alarm status and clear state
    // -------------------------------------------------------------------
    always_comb begin
        alarm_evt = {i_alarm_event, 1'b0};
        alarm_evt[ALARM_PIN_BIT] = alarm_pin_s2;
        // Set wins over a simultaneous write-one-to-clear
        next_alarm_st = (alarm_st & ~alarm_w1c) | alarm_evt;
        alarm_clears = |(alarm_st & clr_src);
        chan_clear = soft_clr | ({NUM_CH{alarm_clears}} & clr_en);
        for (int i = 0; i < NUM_CH; i++) begin
            // Stored values kept; only the DAC input is forced
            next_code[i] = chan_clear[i] ? ZERO_CODE
                : next_active[i];
        end
    end

    // -------------------------------------------------------------------
    // Source_select_a
    // -------------------------------------------------------------------
    always_comb begin
        next_rd_data = rd_data;
        rd_ch = ddu_chan(req.addr);
        if (if_cfg_one[BIT_SOURCE_SELECT_A]) begin
            rd_code = o_dac_clear[rd_ch] ? ZERO_CODE
                : active_reg[rd_ch];
        end else begin
            rd_code = buffer_reg[rd_ch];
        end
        if (rd_req) begin
            case (req.addr)
                ADDR_IF_CFG_ONE: next_rd_data = if_cfg_one;
                ADDR_CLR_EN_0: next_rd_data = clr_en[7:0];
                ADDR_CLR_EN_1: next_rd_data = clr_en[15:8];
                ADDR_CLR_SRC_0: next_rd_data = clr_src[7:0];
                ADDR_CLR_SRC_1: next_rd_data = clr_src[15:8];
                ADDR_SOFT_CLR_0: next_rd_data = soft_clr[7:0];
                ADDR_SOFT_CLR_1: next_rd_data = soft_clr[15:8];
                ADDR_ALARM_ST_0: next_rd_data = alarm_st[7:0];
                ADDR_ALARM_ST_1: next_rd_data = alarm_st[15:8];
                default: begin
                    if (ddu_is_data(req.addr)) begin
                        next_rd_data = req.addr[0]
                            ? DATA_W'(rd_code[CODE_W-1:DATA_W])
                            : rd_code[DATA_W-1:0];
                    end else begin
                        next_rd_data = RST_BYTE;
                    end
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            if_cfg_one <= RST_BYTE;
            clr_en <= RST_MASK;
            clr_src <= RST_MASK;
            soft_clr <= RST_MASK;
            alarm_st <= RST_MASK;
            rd_data <= RST_BYTE;
            o_dac_clamp <= RST_CLAMP;
            o_dac_clear <= RST_MASK;
            for (int i = 0; i < NUM_CH; i++) begin
                buffer_reg[i] <= RST_CODE;
                active_reg[i] <= RST_CODE;
                o_dac_code[i] <= RST_CODE;
            end
        end else begin
            if_cfg_one <= next_if_cfg_one;
            clr_en <= next_clr_en;
            clr_src <= next_clr_src;
            soft_clr <= next_soft_clr;
            alarm_st <= next_alarm_st;
            rd_data <= next_rd_data;
            o_dac_clamp <= next_clamp;
            o_dac_clear <= chan_clear;
            buffer_reg <= next_buffer;
            active_reg <= next_active;
            o_dac_code <= next_code;
        end
    end

endmodule
`default_nettype wire

// [ddu_dac_regs_checker.sv]
// Checker for the DAC data, update and clear block, bound to its ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module ddu_dac_regs_checker
    import ddu_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_csn,
    input wire logic o_sdo,
    input wire logic o_sdo_oe,
    input wire logic i_alarm_input_pin,
    input wire logic [NUM_ALARM-2:0] i_alarm_event,
    input wire ddu_codes_t o_dac_code,
    input wire logic [NUM_CH-1:0] o_dac_clear,
    input wire logic [NUM_CH-1:0] o_dac_clamp
);
    // ---------------------------------------------------------------
    // Cycles since a frame or an alarm cause was last seen
    // ---------------------------------------------------------------
    logic [3:0] since_csn, next_since_csn, since_alarm, next_since_alarm;
    logic [NUM_CH-1:0] bad_zero;
    always_comb begin
        next_since_csn = (since_csn == 4'hF) ? since_csn : since_csn + 4'h1;
        next_since_alarm = (since_alarm == 4'hF) ? since_alarm
                                                 : since_alarm + 4'h1;
        if (!i_csn)
            next_since_csn = 4'h0;
        if (!i_csn || i_alarm_input_pin || (|i_alarm_event))
            next_since_alarm = 4'h0;
        if (i_rst) begin
            next_since_csn = 4'hF;
            next_since_alarm = 4'hF;
        end
        for (int k = 0; k < NUM_CH; k++)
            bad_zero[k] = o_dac_clear[k] && (o_dac_code[k] != ZERO_CODE);
    end
    always_ff @(posedge i_clk) begin
        since_csn <= next_since_csn;
        since_alarm <= next_since_alarm;
    end

    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence seq_csn_idle;
        i_csn [*5];
    endsequence
    sequence seq_clear_rise;
        (o_dac_clear & ~$past(o_dac_clear)) != '0;
    endsequence

    a_reset_defaults: assert property ($fell(i_rst) |->
        o_dac_clamp == RST_CLAMP && o_dac_clear == RST_MASK && o_dac_code == '0)
        else $error("outputs not at defaults after reset");
    a_clear_zero_code: assert property (bad_zero == '0)
        else $error("cleared channel fed a nonzero code");
    a_code_needs_frame: assert property ($changed(o_dac_code) |->
        $changed(o_dac_clear) || since_csn < 4'h8)
        else $error("code moved without a command or clear change");
    a_clamp_needs_frame: assert property ($changed(o_dac_clamp) |->
        since_csn < 4'h8)
        else $error("clamp changed outside a frame");
    a_clamp_stays_off: assert property (o_dac_clamp == '0 |=>
        o_dac_clamp == '0)
        else $error("clamp came back without reset");
    a_clear_has_cause: assert property (seq_clear_rise |->
        since_alarm < 4'h8)
        else $error("channel cleared with no cause");
    a_release_by_frame: assert property (
        (~o_dac_clear & $past(o_dac_clear)) != '0 |-> since_csn < 4'h8)
        else $error("channel left clear without a register write");
    a_sdo_idle: assert property (seq_csn_idle |->
        !o_sdo_oe && !o_sdo)
        else $error("serial output driven while deselected");
    a_sdo_drive: assert property (!i_csn [*5] |-> o_sdo_oe)
        else $error("serial output not enabled while selected");
    c_clear_rise: cover property (seq_clear_rise);
endmodule

bind ddu_dac_regs ddu_dac_regs_checker u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_csn(i_csn), .o_sdo(o_sdo),
    .o_sdo_oe(o_sdo_oe), .i_alarm_input_pin(i_alarm_input_pin),
    .i_alarm_event(i_alarm_event), .o_dac_code(o_dac_code),
    .o_dac_clear(o_dac_clear), .o_dac_clamp(o_dac_clamp)
);
`default_nettype wire

// [ddu_host_model.sv]
// Host controller model: 24-bit mode 0 serial frames, MSB first.
// Assumes read data settles on the serial output before the next rise.
`timescale 1ns/10ps
`default_nettype none
module ddu_host_model (
    input wire logic i_clk,
    input wire logic i_sdo,
    input wire logic i_sdo_oe,
    output logic o_sclk,
    output logic o_csn,
    output logic o_sdi
);
    int half = 6;
    initial begin
        o_sclk = 1'b0;
        o_csn = 1'b1;
        o_sdi = 1'b0;
    end
    // ---------------------------------------------------------------
    // One frame; SCLK rests low and SDI flips once deselected
    // ---------------------------------------------------------------
    task automatic xfer(input logic rd, input logic [7:0] a,
            input logic [7:0] d, output logic [7:0] q);
        logic [23:0] f;
        f = {rd, 7'h00, a, d};
        q = 8'h00;
        @(negedge i_clk);
        o_csn = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            o_sdi = f[i];
            repeat (half) @(negedge i_clk);
            if (i < 8)
                q[i] = i_sdo_oe ? i_sdo : 1'bx;
            o_sclk = 1'b1;
            repeat (half) @(negedge i_clk);
            o_sclk = 1'b0;
        end
        repeat (half) @(negedge i_clk);
        o_csn = 1'b1;
        o_sdi = ~o_sdi;
        repeat (4) @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

// [test_dac_data_update_and_clear.sv]
// Testbench for the DAC data, update and clear block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module test_dac_data_update_and_clear;
    import ddu_pkg::*;
    logic i_clk = 1'b0;
    logic rst = 1'b1;
    logic pin = 1'b0;
    logic [NUM_ALARM-2:0] ev = '0;
    wire logic sclk, csn, sdi;
    logic sdo, sdo_oe;
    ddu_codes_t code;
    logic [NUM_CH-1:0] clr, clamp;
    int failures = 0;
    int tests_run = 0;
    logic [7:0] q;
    logic [CODE_W-1:0] act [NUM_CH];
    logic [CODE_W-1:0] c;

    always #5 i_clk = ~i_clk;

    ddu_dac_regs dut (.i_clk(i_clk), .i_rst(rst), .i_sclk(sclk),
        .i_csn(csn), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
        .i_alarm_input_pin(pin), .i_alarm_event(ev), .o_dac_code(code),
        .o_dac_clear(clr), .o_dac_clamp(clamp));
    ddu_host_model host (.i_clk(i_clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe),
        .o_sclk(sclk), .o_csn(csn), .o_sdi(sdi));

    // ---------------------------------------------------------------
    // Access and compare tasks
    // ---------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, q);
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t byte got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        host.xfer(1'b1, a, 8'h00, q);
        chk_byte(q, exp);
    endtask
    task automatic chk_mask(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t mask got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_codes(input logic [15:0] cm);
        for (int k = 0; k < NUM_CH; k++) begin
            tests_run++;
            if (code[k] !== (cm[k] ? ZERO_CODE : act[k])) begin
                failures++;
                $display("ERROR t=%0t code of channel %0d wrong", $time, k);
            end
        end
    endtask
    task automatic wrap_up;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge i_clk);
        failures++;
        $display("ERROR t=%0t watchdog expired", $time);
        wrap_up();
    end

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    initial begin
        for (int k = 0; k < NUM_CH; k++)
            act[k] = RST_CODE;
        repeat (2) @(negedge i_clk);
        rst = 1'b0;
        @(negedge i_clk);
        chk_mask(clamp, RST_CLAMP);
        chk_mask(clr, RST_MASK);
        chk_codes(16'h0000);
        rd(ADDR_CLR_EN_0, RST_BYTE);
        rd(8'h40, 8'h00);
        for (int k = 0; k < NUM_CH; k++) begin
            c = 12'(k * 12'h111);
            wr(ADDR_DATA_FIRST + 8'(2 * k), c[7:0]);
            wr(ADDR_DATA_FIRST + 8'(2 * k + 1), {4'h0, c[11:8]});
        end
        chk_codes(16'h0000);
        chk_mask(clamp, RST_CLAMP);
        rd(ADDR_DATA_LAST, 8'h0F);
        rd(ADDR_DATA_LAST - 8'h01, 8'hFF);
        wr(ADDR_IF_CFG_ONE, 8'h10);
        rd(ADDR_DATA_LAST, 8'h00);
        host.half = 9;
        wr(ADDR_UPDATE_CMD, 8'h01);
        host.half = 6;
        for (int k = 0; k < NUM_CH; k++)
            act[k] = 12'(k * 12'h111);
        chk_codes(16'h0000);
        chk_mask(clamp, 16'h0000);
        rd(ADDR_DATA_LAST, 8'h0F);
        rd(ADDR_DATA_FIRST, 8'h00);
        rd(ADDR_UPDATE_CMD, 8'h00);
        wr(ADDR_SOFT_CLR_0, 8'h01);
        wr(ADDR_SOFT_CLR_1, 8'h80);
        chk_mask(clr, 16'h8001);
        chk_codes(16'h8001);
        rd(ADDR_DATA_LAST - 8'h01, 8'h00);
        wr(ADDR_IF_CFG_ONE, 8'h00);
        rd(ADDR_DATA_LAST - 8'h01, 8'hFF);
        wr(ADDR_DATA_FIRST, 8'h55);
        wr(ADDR_UPDATE_CMD, 8'h01);
        act[0] = 12'h055;
        chk_mask(clr, 16'h8001);
        chk_codes(16'h8001);
        wr(ADDR_SOFT_CLR_0, 8'h00);
        wr(ADDR_SOFT_CLR_1, 8'h00);
        chk_mask(clr, 16'h0000);
        chk_codes(16'h0000);
        wr(ADDR_CLR_EN_0, 8'h0F);
        wr(ADDR_CLR_EN_1, 8'h80);
        wr(ADDR_CLR_SRC_0, 8'h01);
        ev[0] = 1'b1;
        repeat (4) @(negedge i_clk);
        ev[0] = 1'b0;
        repeat (4) @(negedge i_clk);
        chk_mask(clr, 16'h0000);
        rd(ADDR_ALARM_ST_0, 8'h02);
        wr(ADDR_ALARM_ST_0, 8'h02);
        rd(ADDR_ALARM_ST_0, 8'h00);
        wr(ADDR_CLR_SRC_0, 8'h03);
        pin = 1'b1;
        repeat (8) @(negedge i_clk);
        chk_mask(clr, 16'h800F);
        chk_codes(16'h800F);
        pin = 1'b0;
        ev[0] = 1'b1;
        @(negedge i_clk);
        ev[0] = 1'b0;
        wr(ADDR_ALARM_ST_0, 8'h01);
        chk_mask(clr, 16'h800F);
        wr(ADDR_ALARM_ST_0, 8'h02);
        chk_mask(clr, 16'h0000);
        chk_codes(16'h0000);
        wrap_up();
    end
endmodule
`default_nettype wire
